// ==== hdl/rac_bank.v ====
// Register bank showing the common register access conventions
//
// Behaviour
// - Read/write bits read back the value software last wrote, except that a write of the reserved mode encoding keeps the old mode.
// - Writes to read-only bits are ignored; bits keep hardware value.
// - Write-only bits accept writes; they always read as zero.
// - Reserved bit positions always read as zero.
// - Read-only multi-bit fields never show a reserved encoding.
// - Power reset restores all reset values; soft reset does too, except debug control.
// - Writing one to a clear-alias bit clears the shared bit.
// - Writing one to a set-alias bit sets the shared bit.
// - Both aliases read the same shared value.
// - Same-cycle set and clear on one bit: clear wins.
`include "rac_map.vh"

module rac_bank #(
	parameter DW = 8,
	parameter AW = 3
) (
	// Clock and reset
	input  wire          ref_clk,
	input  wire          srst,
	input  wire          soft_rst,
	// Primary access port
	input  wire          a_wr_en,
	input  wire          a_rd_en,
	input  wire [AW-1:0] a_addr,
	input  wire [DW-1:0] a_wdata,
	output reg  [DW-1:0] a_rdata,
	output reg           a_rd_valid,
	// Secondary write-only port
	input  wire          b_wr_en,
	input  wire [AW-1:0] b_addr,
	input  wire [DW-1:0] b_wdata,
	// Hardware status inputs
	input  wire          hw_busy,
	input  wire [1:0]    hw_state,
	// Control outputs
	output reg           ctrl_enable,
	output reg  [1:0]    ctrl_mode,
	output reg  [2:0]    ctrl_presc,
	output reg           dbg_run,
	output reg  [DW-1:0] flags,
	output reg           cmd_pulse
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire          a_wr_ctrl;
	wire          a_wr_cmd;
	wire          a_wr_dbg;
	wire          a_wr_set;
	wire          a_wr_clr;
	wire          b_wr_ctrl;
	wire          b_wr_cmd;
	wire          b_wr_dbg;
	wire          b_wr_set;
	wire          b_wr_clr;

	assign a_wr_ctrl = a_wr_en && (a_addr == `RAC_ADDR_CTRL);
	assign a_wr_cmd  = a_wr_en && (a_addr == `RAC_ADDR_CMD);
	assign a_wr_dbg  = a_wr_en && (a_addr == `RAC_ADDR_DBGCTRL);
	assign a_wr_set  = a_wr_en && (a_addr == `RAC_ADDR_FLAGSET);
	assign a_wr_clr  = a_wr_en && (a_addr == `RAC_ADDR_FLAGCLR);
	assign b_wr_ctrl = b_wr_en && (b_addr == `RAC_ADDR_CTRL);
	assign b_wr_cmd  = b_wr_en && (b_addr == `RAC_ADDR_CMD);
	assign b_wr_dbg  = b_wr_en && (b_addr == `RAC_ADDR_DBGCTRL);
	assign b_wr_set  = b_wr_en && (b_addr == `RAC_ADDR_FLAGSET);
	assign b_wr_clr  = b_wr_en && (b_addr == `RAC_ADDR_FLAGCLR);

	// ----------------------------------------
	// Write data selection, port A first for control and debug, command ORs both ports
	// ----------------------------------------
	wire          wr_ctrl;
	wire          wr_dbg;
	wire [DW-1:0] ctrl_wdata;
	wire [DW-1:0] dbg_wdata;
	wire [DW-1:0] cmd_wdata;
	wire [DW-1:0] a_cmd_part;
	wire [DW-1:0] b_cmd_part;

	assign wr_ctrl    = a_wr_ctrl | b_wr_ctrl;
	assign wr_dbg     = a_wr_dbg | b_wr_dbg;
	assign ctrl_wdata = a_wr_ctrl ? a_wdata : b_wdata;
	assign dbg_wdata  = a_wr_dbg ? a_wdata : b_wdata;
	assign a_cmd_part = a_wr_cmd ? a_wdata : {DW{1'b0}};
	assign b_cmd_part = b_wr_cmd ? b_wdata : {DW{1'b0}};
	assign cmd_wdata  = a_cmd_part | b_cmd_part;

	// ----------------------------------------
	// Soft reset request
	// ----------------------------------------
	wire          cmd_swrst;
	wire          cmd_go;
	wire          clear_all;

	assign cmd_swrst = cmd_wdata[`RAC_CMD_SWRST_BIT];
	assign cmd_go    = cmd_wdata[`RAC_CMD_PULSE_BIT];
	assign clear_all = soft_rst | cmd_swrst;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	wire [DW-1:0] ctrl_rst_val;
	wire [DW-1:0] dbg_rst_val;
	wire [DW-1:0] flag_rst_val;
	wire [DW-1:0] flag_keep;
	wire          rst_enable;
	wire [1:0]    rst_mode;
	wire [2:0]    rst_presc;

	assign ctrl_rst_val = `RAC_CTRL_RST;
	assign dbg_rst_val  = `RAC_DBG_RST;
	assign flag_rst_val = `RAC_FLAG_RST;
	assign flag_keep    = `RAC_FLAG_MASK;
	assign rst_enable   = ctrl_rst_val[`RAC_CTRL_ENABLE_BIT];
	assign rst_mode     = ctrl_rst_val[`RAC_CTRL_MODE_MSB:`RAC_CTRL_MODE_LSB];
	assign rst_presc    = ctrl_rst_val[`RAC_CTRL_PRESC_MSB:`RAC_CTRL_PRESC_LSB];

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	wire [1:0]    wr_mode;
	wire          mode_ok;
	reg  [DW-1:0] next_ctrl;

	assign wr_mode = ctrl_wdata[`RAC_CTRL_MODE_MSB:`RAC_CTRL_MODE_LSB];
	// Reserved mode encoding keeps the old mode
	assign mode_ok = (wr_mode != `RAC_MODE_RSVD);

	always @* begin
		next_ctrl = {DW{1'b0}};
		next_ctrl[`RAC_CTRL_ENABLE_BIT] = ctrl_enable;
		next_ctrl[`RAC_CTRL_MODE_MSB:`RAC_CTRL_MODE_LSB] = ctrl_mode;
		next_ctrl[`RAC_CTRL_PRESC_MSB:`RAC_CTRL_PRESC_LSB] = ctrl_presc;
		if (wr_ctrl) begin
			next_ctrl[`RAC_CTRL_ENABLE_BIT] = ctrl_wdata[`RAC_CTRL_ENABLE_BIT];
			next_ctrl[`RAC_CTRL_PRESC_MSB:`RAC_CTRL_PRESC_LSB] =
				ctrl_wdata[`RAC_CTRL_PRESC_MSB:`RAC_CTRL_PRESC_LSB];
			if (mode_ok) begin
				next_ctrl[`RAC_CTRL_MODE_MSB:`RAC_CTRL_MODE_LSB] = wr_mode;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (srst || clear_all) begin
			ctrl_enable <= rst_enable;
		end else begin
			ctrl_enable <= next_ctrl[`RAC_CTRL_ENABLE_BIT];
		end
	end

	always @(posedge ref_clk) begin
		if (srst || clear_all) begin
			ctrl_mode <= rst_mode;
		end else begin
			ctrl_mode <= next_ctrl[`RAC_CTRL_MODE_MSB:`RAC_CTRL_MODE_LSB];
		end
	end

	always @(posedge ref_clk) begin
		if (srst || clear_all) begin
			ctrl_presc <= rst_presc;
		end else begin
			ctrl_presc <= next_ctrl[`RAC_CTRL_PRESC_MSB:`RAC_CTRL_PRESC_LSB];
		end
	end

	// ----------------------------------------
	// Debug control, kept over soft reset
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			dbg_run <= dbg_rst_val[`RAC_DBG_RUN_BIT];
		end else if (wr_dbg) begin
			dbg_run <= dbg_wdata[`RAC_DBG_RUN_BIT];
		end
	end

	// ----------------------------------------
	// Set/clear alias pair
	// ----------------------------------------
	wire [DW-1:0] next_flags;
	genvar        fb;

	// One cell per bit, both ports ORed
	generate
		for (fb = 0; fb < DW; fb = fb + 1) begin : g_flag_bit
			wire bit_set;
			wire bit_clr;

			assign bit_set = (a_wr_set & a_wdata[fb]) | (b_wr_set & b_wdata[fb]);
			assign bit_clr = (a_wr_clr & a_wdata[fb]) | (b_wr_clr & b_wdata[fb]);
			// Zero bits leave state alone; clear applied last wins
			assign next_flags[fb] = (flags[fb] | bit_set) & ~bit_clr;
		end
	endgenerate

	always @(posedge ref_clk) begin
		if (srst || clear_all) begin
			flags <= flag_rst_val;
		end else begin
			flags <= next_flags & flag_keep;
		end
	end

	// ----------------------------------------
	// Write-only command strobe
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			cmd_pulse <= 1'b0;
		end else begin
			// No pulse when the same write also resets
			cmd_pulse <= cmd_go && !clear_all;
		end
	end

	// ----------------------------------------
	// Read-only status
	// ----------------------------------------
	reg  [1:0]    state_safe;

	always @* begin
		// Reserved state code is never shown
		if (hw_state == `RAC_STATE_RSVD) begin
			state_safe = `RAC_STATE_SAFE;
		end else begin
			state_safe = hw_state;
		end
	end

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	reg  [DW-1:0] rd_mux;

	always @* begin
		rd_mux = {DW{1'b0}};
		case (a_addr)
			`RAC_ADDR_CTRL: begin
				rd_mux[`RAC_CTRL_ENABLE_BIT] = ctrl_enable;
				rd_mux[`RAC_CTRL_MODE_MSB:`RAC_CTRL_MODE_LSB] = ctrl_mode;
				rd_mux[`RAC_CTRL_PRESC_MSB:`RAC_CTRL_PRESC_LSB] = ctrl_presc;
			end
			`RAC_ADDR_STATUS: begin
				// Writes here decode to nothing
				rd_mux[`RAC_STATUS_BUSY_BIT] = hw_busy;
				rd_mux[`RAC_STATUS_STATE_MSB:`RAC_STATUS_STATE_LSB] = state_safe;
			end
			`RAC_ADDR_CMD: begin
				rd_mux = {DW{1'b0}};
			end
			`RAC_ADDR_DBGCTRL: begin
				rd_mux[`RAC_DBG_RUN_BIT] = dbg_run;
			end
			`RAC_ADDR_FLAGSET: begin
				rd_mux = flags;
			end
			`RAC_ADDR_FLAGCLR: begin
				rd_mux = flags;
			end
			default: begin
				rd_mux = {DW{1'b0}};
			end
		endcase
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	// Reserved and write-only bits masked to zero
	reg  [DW-1:0] rd_keep;

	always @* begin
		case (a_addr)
			`RAC_ADDR_CTRL:    rd_keep = `RAC_CTRL_MASK;
			`RAC_ADDR_STATUS:  rd_keep = `RAC_STATUS_MASK;
			`RAC_ADDR_CMD:     rd_keep = {DW{1'b0}};
			`RAC_ADDR_DBGCTRL: rd_keep = `RAC_DBG_MASK;
			`RAC_ADDR_FLAGSET: rd_keep = `RAC_FLAG_MASK;
			`RAC_ADDR_FLAGCLR: rd_keep = `RAC_FLAG_MASK;
			default:           rd_keep = {DW{1'b0}};
		endcase
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			a_rdata    <= {DW{1'b0}};
			a_rd_valid <= 1'b0;
		end else begin
			a_rd_valid <= a_rd_en;
			if (a_rd_en) begin
				a_rdata <= rd_mux & rd_keep;
			end
		end
	end

endmodule // rac_bank

// ==== hdl/rac_map.vh ====
// Offsets, field masks and reset values of the register bank
`ifndef RAC_MAP_VH
`define RAC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RAC_ADDR_CTRL    3'h0
`define RAC_ADDR_STATUS  3'h1
`define RAC_ADDR_CMD     3'h2
`define RAC_ADDR_DBGCTRL 3'h3
`define RAC_ADDR_FLAGSET 3'h4
`define RAC_ADDR_FLAGCLR 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RAC_CTRL_ENABLE_BIT   0
`define RAC_CTRL_MODE_LSB     1
`define RAC_CTRL_MODE_MSB     2
`define RAC_CTRL_PRESC_LSB    4
`define RAC_CTRL_PRESC_MSB    6
`define RAC_STATUS_BUSY_BIT   0
`define RAC_STATUS_STATE_LSB  1
`define RAC_STATUS_STATE_MSB  2
`define RAC_CMD_SWRST_BIT     0
`define RAC_CMD_PULSE_BIT     1
`define RAC_DBG_RUN_BIT       0

// ----------------------------------------
// Implemented-bit masks (others reserved)
// ----------------------------------------
`define RAC_CTRL_MASK    8'h77
`define RAC_STATUS_MASK  8'h07
`define RAC_DBG_MASK     8'h01
`define RAC_FLAG_MASK    8'hff

// ----------------------------------------
// Reserved encodings and reset values
// ----------------------------------------
`define RAC_MODE_RSVD    2'h3
`define RAC_STATE_RSVD   2'h3
`define RAC_STATE_SAFE   2'h0
`define RAC_CTRL_RST     8'h00
`define RAC_DBG_RST      8'h00
`define RAC_FLAG_RST     8'h00

`endif

// ==== testbench/rac_bank_monitor.sv ====
// Checker of the register bank conventions
module rac_bank_monitor #(
	parameter DW = 8,
	parameter AW = 3
) (
	// Clock and resets
	input wire          ref_clk,
	input wire          srst,
	input wire          soft_rst,
	// Access ports
	input wire          a_wr_en,
	input wire          a_rd_en,
	input wire [AW-1:0] a_addr,
	input wire [DW-1:0] a_wdata,
	input wire [DW-1:0] a_rdata,
	input wire          a_rd_valid,
	input wire          b_wr_en,
	input wire          hw_busy,
	// Register outputs
	input wire          ctrl_enable,
	input wire [1:0]    ctrl_mode,
	input wire [2:0]    ctrl_presc,
	input wire          dbg_run,
	input wire [DW-1:0] flags
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	a_rd_answer: assert property (a_rd_en |=> a_rd_valid)
		else $error("read answer missing");
	a_ctrl_wr: assert property (a_wr_en && a_addr == 3'h0 && !soft_rst && !b_wr_en
		|=> ctrl_presc == $past(a_wdata[6:4]) && ctrl_enable == $past(a_wdata[0]))
		else $error("control write lost");
	a_status_busy: assert property (a_rd_en && a_addr == 3'h1
		|=> a_rdata[0] == $past(hw_busy)) else $error("status busy wrong");
	a_unmapped_zero: assert property (a_rd_en && a_addr > 3'h5
		|=> a_rdata == 8'h00) else $error("unmapped read not zero");
	a_ctrl_rsvd: assert property (a_rd_en && a_addr == 3'h0
		|=> !a_rdata[7] && !a_rdata[3]) else $error("reserved bit set");
	a_state_legal: assert property (a_rd_en && a_addr == 3'h1
		|=> a_rdata[2:1] != 2'h3 && a_rdata[7:3] == 5'h00) else $error("bad state code");
	a_alias_same: assert property (a_rd_en && a_addr[2:1] == 2'h2
		|=> a_rdata == $past(flags)) else $error("alias read differs");
	a_set_bits: assert property (a_wr_en && a_addr == 3'h4 && !b_wr_en && !soft_rst
		|=> flags == ($past(flags) | $past(a_wdata))) else $error("set alias wrong");
	a_clr_wins: assert property (a_wr_en && a_addr == 3'h5 && !soft_rst
		|=> (flags & $past(a_wdata)) == 8'h00) else $error("clear alias wrong");
	a_soft_rst: assert property (soft_rst && !a_wr_en && !b_wr_en
		|=> flags == 8'h00 && !ctrl_enable && ctrl_mode == 2'h0 && $stable(dbg_run))
		else $error("soft reset wrong");
endmodule // rac_bank_monitor

// ==== testbench/rac_bank_tb_top.sv ====
// Self-checking bench of the register bank
module rac_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk, srst, soft_rst, a_wr_en, a_rd_en, b_wr_en, hw_busy;
	logic [2:0] a_addr, b_addr, ctrl_presc, ra, rb;
	logic [7:0] a_wdata, b_wdata, a_rdata, flags, m_ctrl, m_flags, pe;
	logic [1:0] hw_state, ctrl_mode;
	logic       a_rd_valid, ctrl_enable, dbg_run, cmd_pulse, m_dbg, m_pulse, pv, pc;
	integer     num_errors = 0, n_tests = 0, seed = 32'h38c1acce, i;

	rac_bank i_rac_bank (.ref_clk(ref_clk), .srst(srst), .soft_rst(soft_rst),
		.a_wr_en(a_wr_en), .a_rd_en(a_rd_en), .a_addr(a_addr), .a_wdata(a_wdata),
		.a_rdata(a_rdata), .a_rd_valid(a_rd_valid), .b_wr_en(b_wr_en), .b_addr(b_addr),
		.b_wdata(b_wdata), .hw_busy(hw_busy), .hw_state(hw_state),
		.ctrl_enable(ctrl_enable), .ctrl_mode(ctrl_mode), .ctrl_presc(ctrl_presc),
		.dbg_run(dbg_run), .flags(flags), .cmd_pulse(cmd_pulse));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	function automatic logic [7:0] rd_exp(input logic [2:0] ad);
		case (ad)
			3'h0: rd_exp = m_ctrl;
			3'h1: rd_exp = {5'h00, (hw_state == 2'h3) ? 2'h0 : hw_state, hw_busy};
			3'h3: rd_exp = {7'h00, m_dbg};
			3'h4, 3'h5: rd_exp = m_flags;
			default: rd_exp = 8'h00;
		endcase
	endfunction

	// Software keeps reserved bits and codes clear; no fuse byte exists to write
	function automatic logic [7:0] sw_val(input logic [2:0] ad, input logic [7:0] d);
		case (ad)
			3'h0: sw_val = d & ((d[2:1] == 2'h3) ? 8'h73 : 8'h77);
			3'h1: sw_val = d & 8'h07;
			3'h2: sw_val = d & 8'h03;
			3'h3: sw_val = d & 8'h01;
			default: sw_val = d;
		endcase
	endfunction

	// One cycle: check last results, drive, update model
	task step(input logic aw, ar, input logic [2:0] aa, input logic [7:0] ad,
		input logic bw, input logic [2:0] ba, input logic [7:0] bd, input logic sr);
		logic sft;
		@(negedge ref_clk);
		chk({7'h00, a_rd_valid}, {7'h00, pv});
		if (pv && !pc) chk(a_rdata, pe);
		chk({1'b0, ctrl_presc, 1'b0, ctrl_mode, ctrl_enable}, m_ctrl);
		chk(flags, m_flags);
		chk({6'h00, dbg_run, cmd_pulse}, {6'h00, m_dbg, m_pulse});
		{a_wr_en, a_rd_en, a_addr, a_wdata} = {aw, ar, aa, ad};
		{b_wr_en, b_addr, b_wdata, soft_rst} = {bw, ba, bd, sr};
		hw_busy = $random(seed);
		hw_state = $random(seed);
		pv = ar;
		pc = (aa == 3'h2);
		pe = rd_exp(aa);
		sft = sr | (aw && aa == 3'h2 && ad[0]) | (bw && ba == 3'h2 && bd[0]);
		m_pulse = !sft && ((aw && aa == 3'h2 && ad[1]) || (bw && ba == 3'h2 && bd[1]));
		// Debug control takes its write even during a soft reset
		if (bw && ba == 3'h3) m_dbg = bd[0];
		if (aw && aa == 3'h3) m_dbg = ad[0];
		if (sft) begin
			m_ctrl = 8'h00;
			m_flags = 8'h00;
		end else begin
			if (bw && ba == 3'h0) m_ctrl = bd & 8'h77;
			if (aw && aa == 3'h0) m_ctrl = ad & 8'h77;
			m_flags = (m_flags | (aw && aa == 3'h4 ? ad : 8'h00) | (bw && ba == 3'h4 ? bd : 8'h00))
				& ~((aw && aa == 3'h5 ? ad : 8'h00) | (bw && ba == 3'h5 ? bd : 8'h00));
		end
	endtask

	initial begin
		{srst, soft_rst, a_wr_en, a_rd_en, b_wr_en, hw_busy} = 6'h20;
		{a_addr, b_addr, a_wdata, b_wdata, hw_state} = 24'h000000;
		{m_ctrl, m_flags, m_dbg, m_pulse, pv, pc} = 20'h00000;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) srst = 1'b0;
		step(1, 0, 3'h3, 8'h01, 0, 3'h0, 8'h00, 0);
		step(1, 1, 3'h4, 8'hff, 1, 3'h5, 8'h0f, 0);
		step(1, 1, 3'h5, 8'h00, 1, 3'h4, 8'h00, 0);
		step(1, 1, 3'h0, 8'h75, 1, 3'h0, 8'h12, 0);
		step(1, 1, 3'h1, 8'h07, 1, 3'h7, 8'hff, 0);
		step(1, 1, 3'h2, 8'h02, 1, 3'h6, 8'hff, 0);
		step(0, 1, 3'h7, 8'h00, 0, 3'h0, 8'h00, 1);
		step(0, 1, 3'h3, 8'h00, 1, 3'h2, 8'h01, 0);
		for (i = 0; i < 1500; i++) begin
			ra = $random(seed);
			rb = $random(seed);
			step($random(seed), $random(seed), ra, sw_val(ra, $random(seed)),
				$random(seed), rb, sw_val(rb, $random(seed)), ($random(seed) & 15) == 0);
		end
		step(1, 0, 3'h3, 8'h01, 1, 3'h4, 8'h5a, 0);
		step(0, 0, 3'h0, 8'h00, 0, 3'h0, 8'h00, 0);
		// Mid-run reset clears debug control as well
		srst = 1'b1;
		@(negedge ref_clk) srst = 1'b0;
		{m_ctrl, m_flags, m_dbg, m_pulse, pv, pc} = 20'h00000;
		step(0, 0, 3'h0, 8'h00, 0, 3'h0, 8'h00, 0);
		step(0, 0, 3'h0, 8'h00, 0, 3'h0, 8'h00, 0);
		conclude;
	end

	initial begin
		repeat (3000) @(posedge ref_clk);
		num_errors++;
		conclude;
	end
endmodule // rac_bank_tb_top

bind rac_bank rac_bank_monitor #(.DW(DW), .AW(AW)) i_rac_bank_monitor (.ref_clk(ref_clk),
	.srst(srst), .soft_rst(soft_rst), .a_wr_en(a_wr_en), .a_rd_en(a_rd_en), .a_addr(a_addr),
	.a_wdata(a_wdata), .a_rdata(a_rdata), .a_rd_valid(a_rd_valid), .b_wr_en(b_wr_en),
	.hw_busy(hw_busy), .ctrl_enable(ctrl_enable), .ctrl_mode(ctrl_mode),
	.ctrl_presc(ctrl_presc), .dbg_run(dbg_run), .flags(flags));
